// file: qsp_pkg.sv
/*
 * Shared constants and types for the quad column strobe page memory controller.
 * Assumes a single 125 MHz clock and pins that are sampled and driven on that clock.
 */
`default_nettype none
package qsp_pkg;
	localparam int ROW_BITS = 10;
	localparam int ADDR_BITS = 20;
	localparam int LANES = 4;
	localparam int CLK_NS = 8;
	// Times as printed, in nanoseconds.
	localparam int T_RP_NS = 50;
	localparam int T_RCD_NS = 20;
	localparam int T_CAS_NS = 20;
	localparam int T_CP_NS = 10;
	localparam int T_RAS_NS = 70;
	localparam int T_CSR_NS = 10;
	localparam int T_INIT_NS = 100000;
	localparam int T_REF_NS = 16000000;
	localparam int REF_ROWS = 1024;
	localparam int INIT_REFRESHES = 8;
	// Least times round up, the refresh interval rounds down.
	localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
	localparam int RCD_CYC = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
	localparam int CAS_CYC = (T_CAS_NS + CLK_NS - 1) / CLK_NS;
	localparam int CP_CYC = (T_CP_NS + CLK_NS - 1) / CLK_NS;
	localparam int RAS_CYC = (T_RAS_NS + CLK_NS - 1) / CLK_NS;
	localparam int CSR_CYC = (T_CSR_NS + CLK_NS - 1) / CLK_NS;
	localparam int INIT_CYC = (T_INIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int REFI_CYC = T_REF_NS / REF_ROWS / CLK_NS;
	localparam int WAIT_W = 4;
	localparam int TIMER_W = 14;
	localparam logic [3:0] STROBES_IDLE = 4'hF;

	typedef enum logic [3:0] {
		QSP_INIT = 4'h0,
		QSP_IDLE = 4'h1,
		QSP_PRE = 4'h2,
		QSP_ROW = 4'h3,
		QSP_COLSET = 4'h4,
		QSP_COL = 4'h5,
		QSP_CASH = 4'h6,
		QSP_CBR_CAS = 4'h7,
		QSP_CBR_RAS = 4'h8,
		QSP_HID_UP = 4'h9,
		QSP_HID_DN = 4'hA
	} qsp_state_t;

	typedef struct packed {
		logic row_strobe_n;
		logic [LANES-1:0] column_strobe_n;
		logic write_enable_n;
		logic output_enable_n;
		logic [ROW_BITS-1:0] multiplexed_address_pins;
	} qsp_pins_t;

	typedef struct packed {
		logic write;
		logic [LANES-1:0] lanes;
		logic [ADDR_BITS-1:0] addr;
		logic [LANES-1:0] wdata;
	} qsp_req_t;
endpackage : qsp_pkg
`default_nettype wire

// file: qsp_ctrl.sv
/*
 * Host controller for a quad column strobe, fast page, 1M x 4 dynamic memory.
 * Assumes the memory pins are synchronous to clk and the board resolves the data wires.
 */
// How it works
// - Row half goes out at the row strobe fall, column half at the column strobe fall.
// - Write enable low selects a write, high selects a read.
// - A page starts with a row strobe, then the first column strobe.
// - With row strobe held low, column strobes toggle for new columns in that row.
// - All 1024 rows are refreshed within every 16 ms.
// - At least one column strobe must fall for a valid column cycle.
// - All column strobes are high before the row strobe falls for a fresh cycle.
// - After power-up wait 100 us, then issue eight refresh cycles.
`timescale 1ns/10ps
`default_nettype none
module qsp_ctrl #(
	parameter int INIT_CYCLES = qsp_pkg::INIT_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// User request
	input wire logic req_valid,
	input wire qsp_pkg::qsp_req_t req,
	output logic req_ready,
	// User read answer
	output logic rd_valid,
	output logic [qsp_pkg::LANES-1:0] rd_data,
	// Memory control and address pins
	output qsp_pkg::qsp_pins_t pins,
	// Memory data pins
	input wire logic [qsp_pkg::LANES-1:0] data_pin_in,
	output logic [qsp_pkg::LANES-1:0] data_pin_out,
	output logic [qsp_pkg::LANES-1:0] data_pin_oe
);
	qsp_pkg::qsp_state_t state, next_state;
	qsp_pkg::qsp_req_t cur, next_cur;
	qsp_pkg::qsp_pins_t next_pins;
	logic [qsp_pkg::WAIT_W-1:0] cnt, next_cnt;
	logic [qsp_pkg::WAIT_W-1:0] ras_age;
	logic [qsp_pkg::TIMER_W-1:0] timer;
	logic [qsp_pkg::ROW_BITS-1:0] open_row;
	logic [3:0] init_left;
	logic have_req, next_have, ref_pend, initialised;

	wire take = req_valid & req_ready;
	wire timer_done = (timer == '0);
	wire wait_done = (cnt == '0);
	wire ras_ok = (ras_age >= qsp_pkg::WAIT_W'(qsp_pkg::RAS_CYC));
	wire ref_need = ref_pend | (init_left != 4'h0);
	wire [qsp_pkg::ROW_BITS-1:0] cur_row = cur.addr[qsp_pkg::ADDR_BITS-1:qsp_pkg::ROW_BITS];
	wire [qsp_pkg::ROW_BITS-1:0] cur_col = cur.addr[qsp_pkg::ROW_BITS-1:0];
	wire page_hit = have_req & (cur_row == open_row) & !ref_need;
	// A request with no lane selected would be no column cycle, so it uses all four.
	wire [qsp_pkg::LANES-1:0] lanes_sel = (cur.lanes == '0) ? qsp_pkg::STROBES_IDLE : cur.lanes;
	wire [qsp_pkg::LANES-1:0] next_lanes = (next_cur.lanes == '0) ? qsp_pkg::STROBES_IDLE
		: next_cur.lanes;
	wire col_end = (state == qsp_pkg::QSP_COL) & wait_done;
	wire rd_sample = col_end & !cur.write;

	function automatic logic [qsp_pkg::WAIT_W-1:0] load(input int cycles);
		load = qsp_pkg::WAIT_W'(cycles - 1);
	endfunction : load

	function automatic logic row_low(input qsp_pkg::qsp_state_t s);
		row_low = (s == qsp_pkg::QSP_ROW) | (s == qsp_pkg::QSP_COLSET) | (s == qsp_pkg::QSP_COL)
			| (s == qsp_pkg::QSP_CASH) | (s == qsp_pkg::QSP_CBR_RAS) | (s == qsp_pkg::QSP_HID_DN);
	endfunction : row_low

	function automatic logic in_col(input qsp_pkg::qsp_state_t s);
		in_col = (s == qsp_pkg::QSP_COLSET) | (s == qsp_pkg::QSP_COL);
	endfunction : in_col

	always_comb
	begin
		next_state = state;
		next_cnt = wait_done ? cnt : cnt - 1'b1;
		next_cur = take ? req : cur;
		next_have = have_req | take;
		case (state)
			qsp_pkg::QSP_INIT:
				if (timer_done)
				begin
					next_state = qsp_pkg::QSP_IDLE;
				end
			qsp_pkg::QSP_IDLE:
				if (ref_need)
				begin
					next_state = qsp_pkg::QSP_CBR_CAS;
					next_cnt = load(qsp_pkg::CSR_CYC);
				end
				else if (have_req)
				begin
					next_state = qsp_pkg::QSP_ROW;
					next_cnt = load(qsp_pkg::RCD_CYC);
				end
			qsp_pkg::QSP_ROW:
				if (wait_done)
				begin
					next_state = qsp_pkg::QSP_COLSET;
				end
			qsp_pkg::QSP_COLSET:
			begin
				next_state = qsp_pkg::QSP_COL;
				next_cnt = load(qsp_pkg::CAS_CYC);
			end
			qsp_pkg::QSP_COL:
				if (wait_done)
				begin
					next_have = take;
					// A read can be followed by a hidden refresh while its strobe stays low.
					if (ref_pend & !cur.write & ras_ok)
					begin
						next_state = qsp_pkg::QSP_HID_UP;
						next_cnt = load(qsp_pkg::RP_CYC);
					end
					else
					begin
						next_state = qsp_pkg::QSP_CASH;
						next_cnt = load(qsp_pkg::CP_CYC);
					end
				end
			qsp_pkg::QSP_CASH:
				if (wait_done & page_hit)
				begin
					next_state = qsp_pkg::QSP_COLSET;
				end
				else if (wait_done & ras_ok)
				begin
					next_state = qsp_pkg::QSP_PRE;
					next_cnt = load(qsp_pkg::RP_CYC);
				end
			qsp_pkg::QSP_CBR_CAS:
				if (wait_done)
				begin
					next_state = qsp_pkg::QSP_CBR_RAS;
					next_cnt = load(qsp_pkg::RAS_CYC);
				end
			qsp_pkg::QSP_HID_UP:
				if (wait_done)
				begin
					next_state = qsp_pkg::QSP_HID_DN;
					next_cnt = load(qsp_pkg::RAS_CYC);
				end
			qsp_pkg::QSP_CBR_RAS, qsp_pkg::QSP_HID_DN:
				if (wait_done)
				begin
					next_state = qsp_pkg::QSP_PRE;
					next_cnt = load(qsp_pkg::RP_CYC);
				end
			qsp_pkg::QSP_PRE:
				if (wait_done)
				begin
					next_state = qsp_pkg::QSP_IDLE;
				end
			default:
				next_state = qsp_pkg::QSP_INIT;
		endcase
	end

	// Pin levels follow the state being entered, so every pin leaves a flip-flop.
	wire next_row_low = row_low(next_state);
	wire next_in_col = in_col(next_state);
	wire next_hid = (next_state == qsp_pkg::QSP_HID_UP) | (next_state == qsp_pkg::QSP_HID_DN);
	wire next_cbr = (next_state == qsp_pkg::QSP_CBR_CAS) | (next_state == qsp_pkg::QSP_CBR_RAS);
	wire next_cas_low = (next_state == qsp_pkg::QSP_COL) | next_hid;
	wire next_write = next_in_col & next_cur.write;
	assign next_pins.row_strobe_n = !next_row_low;
	// Only the selected lanes fall, except in a CBR refresh, where all four fall; the rest stay high all cycle.
	assign next_pins.column_strobe_n = next_cbr ? '0
		: next_cas_low ? ~next_lanes : qsp_pkg::STROBES_IDLE;
	// Write enable falls one cycle before the strobe, giving an early write.
	assign next_pins.write_enable_n = !next_write;
	assign next_pins.output_enable_n = !((next_in_col | next_hid) & !next_cur.write);
	assign next_pins.multiplexed_address_pins = next_in_col
		? next_cur.addr[qsp_pkg::ROW_BITS-1:0]
		: next_cur.addr[qsp_pkg::ADDR_BITS-1:qsp_pkg::ROW_BITS];

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state <= qsp_pkg::QSP_INIT;
			cnt <= '0;
			cur <= '0;
			have_req <= 1'b0;
			req_ready <= 1'b0;
			pins <= '{1'b1, qsp_pkg::STROBES_IDLE, 1'b1, 1'b1, '0};
			data_pin_out <= '0;
			data_pin_oe <= '0;
			rd_valid <= 1'b0;
			rd_data <= '0;
			ras_age <= '0;
			open_row <= '0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			cur <= next_cur;
			have_req <= next_have;
			req_ready <= !next_have & (next_state != qsp_pkg::QSP_INIT) & !next_hid;
			pins <= next_pins;
			data_pin_out <= next_cur.wdata;
			data_pin_oe <= next_write ? next_lanes : '0;
			rd_valid <= rd_sample;
			rd_data <= rd_sample ? data_pin_in : rd_data;
			ras_age <= !next_row_low ? '0 : (ras_ok ? ras_age : ras_age + 1'b1);
			open_row <= (next_state == qsp_pkg::QSP_ROW) ? next_cur.addr[qsp_pkg::ADDR_BITS-1:
				qsp_pkg::ROW_BITS] : open_row;
		end
	end

	// One refresh every interval keeps all rows inside the refresh period; the device counts rows.
	wire ref_start = (state == qsp_pkg::QSP_IDLE) & ref_need
		| (col_end & (next_state == qsp_pkg::QSP_HID_UP));
	logic [qsp_pkg::TIMER_W:0] since_ref;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			timer <= qsp_pkg::TIMER_W'(INIT_CYCLES - 1);
			initialised <= 1'b0;
			init_left <= 4'h0;
			ref_pend <= 1'b0;
			since_ref <= '0;
		end
		else
		begin
			timer <= timer_done ? qsp_pkg::TIMER_W'(qsp_pkg::REFI_CYC - 1) : timer - 1'b1;
			initialised <= initialised | timer_done;
			if (timer_done & !initialised)
				init_left <= 4'(qsp_pkg::INIT_REFRESHES);
			else if (ref_start & !ref_pend & (init_left != 4'h0))
				init_left <= init_left - 4'h1;
			// A new interval expiring in the cycle a refresh starts is kept.
			ref_pend <= (timer_done & initialised) | (ref_pend & !ref_start);
			since_ref <= (ref_start | !initialised) ? '0 : since_ref + 1'b1;
		end
	end

	AST_ROW_ADDR: assert property (@(posedge clk) disable iff (!rstn)
		$fell(pins.row_strobe_n) && $past(state) == qsp_pkg::QSP_IDLE
		|-> pins.multiplexed_address_pins == cur_row)
		else $error("Row address not on pins at row strobe fall.");
	AST_COL_ADDR: assert property (@(posedge clk) disable iff (!rstn)
		state == qsp_pkg::QSP_COL && $past(state) == qsp_pkg::QSP_COLSET
		|-> pins.multiplexed_address_pins == cur_col && pins.column_strobe_n == ~lanes_sel)
		else $error("Column address or strobes wrong at column strobe fall.");
	AST_EARLY_WE: assert property (@(posedge clk) disable iff (!rstn)
		state == qsp_pkg::QSP_COL && $past(state) == qsp_pkg::QSP_COLSET
		|-> $past(pins.write_enable_n) == !cur.write && pins.write_enable_n == !cur.write)
		else $error("Write enable not set up before the column strobe.");
	AST_FRESH_ROW: assert property (@(posedge clk) disable iff (!rstn)
		$fell(pins.row_strobe_n) && state inside {qsp_pkg::QSP_ROW}
		|-> $past(pins.column_strobe_n) == qsp_pkg::STROBES_IDLE)
		else $error("Row strobe fell with a column strobe low.");
	AST_ONE_LANE: assert property (@(posedge clk) disable iff (!rstn)
		state == qsp_pkg::QSP_COL |-> pins.column_strobe_n != qsp_pkg::STROBES_IDLE)
		else $error("Column cycle with no strobe low.");
	AST_NO_FIGHT: assert property (@(posedge clk) disable iff (!rstn)
		data_pin_oe != '0 |-> !pins.write_enable_n && pins.output_enable_n
		&& (data_pin_oe & ~lanes_sel) == '0)
		else $error("Data driven while device may drive.");
	AST_REF_GAP: assert property (@(posedge clk) disable iff (!rstn)
		since_ref < (qsp_pkg::TIMER_W + 1)'(qsp_pkg::REFI_CYC + 64))
		else $error("Refresh interval overrun.");
	AST_INIT_QUIET: assert property (@(posedge clk) disable iff (!rstn)
		state == qsp_pkg::QSP_INIT |-> pins.row_strobe_n && !req_ready)
		else $error("Activity during power-up wait.");
	AST_PAGE_KEEP: assert property (@(posedge clk) disable iff (!rstn)
		state == qsp_pkg::QSP_CASH ##1 state == qsp_pkg::QSP_COLSET
		|-> !pins.row_strobe_n && !$past(pins.row_strobe_n))
		else $error("Row strobe rose inside a page.");
	AST_HIDDEN: assert property (@(posedge clk) disable iff (!rstn)
		state inside {qsp_pkg::QSP_HID_UP, qsp_pkg::QSP_HID_DN}
		|-> (pins.row_strobe_n || state == qsp_pkg::QSP_HID_DN) && $stable(pins.column_strobe_n))
		else $error("Column strobe moved during hidden refresh.");
endmodule : qsp_ctrl
`default_nettype wire

// file: qsp_mem_model.sv
/*
 * Behavioural model of the quad strobe page memory, sampled on the controller clock.
 * Assumes pins change just after rising edges and the bench resolves the data wires.
 */
`timescale 1ns/10ps
`default_nettype none
module qsp_mem_model (
	// Clock
	input wire logic clk,
	// Memory pins
	input wire qsp_pkg::qsp_pins_t pins,
	input wire logic [3:0] dq_bus,
	output logic [3:0] dq_out,
	output logic [3:0] dq_oe,
	// Observation
	output int row_falls,
	output int refreshes,
	output logic [9:0] refresh_row
);
	bit [3:0] mem [0:1048575];
	logic ras_q = 1'b0;
	logic cas_q = 1'b0;
	logic we_q = 1'b1;
	logic ew = 1'b0;
	logic [9:0] row = 10'h000;
	logic [9:0] col = 10'h000;
	wire logic ras = ~pins.row_strobe_n;
	wire logic cas_any = ~&pins.column_strobe_n;
	wire logic cas_fell = ras & cas_any & ~cas_q;
	wire logic [9:0] col_now = cas_fell ? pins.multiplexed_address_pins : col;
	wire logic wr_now = ras & cas_any & ~pins.write_enable_n & (~cas_q | we_q);
	// The flag is latched at the strobe fall, so an early write never turns a lane round.
	assign dq_oe = ~pins.column_strobe_n & {4{~pins.output_enable_n & ~ew}};
	initial
	begin
		row_falls = 0;
		refreshes = 0;
		refresh_row = 10'h000;
		dq_out = 4'h0;
	end
	always @(posedge clk)
	begin
		ras_q <= ras;
		cas_q <= cas_any;
		we_q <= pins.write_enable_n;
		if (ras & ~ras_q)
		begin
			row_falls <= row_falls + 1;
			if (cas_any)
			begin
				refreshes <= refreshes + 1;
				refresh_row <= refresh_row + 10'h001;
			end
			else
				row <= pins.multiplexed_address_pins;
		end
		if (cas_fell)
		begin
			col <= pins.multiplexed_address_pins;
			ew <= ~pins.write_enable_n;
			dq_out <= mem[{row, pins.multiplexed_address_pins}];
		end
		if (wr_now)
			for (int i = 0; i < 4; i++)
				if (!pins.column_strobe_n[i])
					mem[{row, col_now}][i] <= dq_bus[i];
	end
endmodule : qsp_mem_model
`default_nettype wire

// file: qsp_testbench.sv
/*
 * Self-checking bench for the quad strobe page controller against a memory model.
 * Assumes a 125 MHz clock and a shortened init wait of 50 cycles.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic req_valid = 1'b0;
	qsp_pkg::qsp_req_t req = '0;
	logic req_ready, rd_valid;
	logic [3:0] rd_data, dq_in, ctl_out, ctl_oe, mem_out, mem_oe;
	logic [3:0] dq_last = 4'h0;
	logic [3:0] rd_last = 4'h0;
	qsp_pkg::qsp_pins_t pins;
	int row_falls, refreshes, f, r;
	logic [9:0] refresh_row;
	int fail_count = 0;
	int samples_checked = 0;
	int rd_count = 0;
	int hid_cycles = 0;
	always #4 clk = ~clk;
	qsp_ctrl #(.INIT_CYCLES(50)) u_dut (.clk(clk), .rstn(rstn), .req_valid(req_valid),
		.req(req), .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .pins(pins),
		.data_pin_in(dq_in), .data_pin_out(ctl_out), .data_pin_oe(ctl_oe));
	qsp_mem_model u_mem (.clk(clk), .pins(pins), .dq_bus(dq_in), .dq_out(mem_out),
		.dq_oe(mem_oe), .row_falls(row_falls), .refreshes(refreshes), .refresh_row(refresh_row));
	// A released wire shows the inverse of its last level, so stale data never reads as good.
	assign dq_in = (ctl_oe & ctl_out) | (~ctl_oe & mem_oe & mem_out) | (~ctl_oe & ~mem_oe & ~dq_last);
	always @(posedge clk)
	begin
		dq_last <= dq_in;
		// Row high with only the first strobe low is the hidden refresh gap of a lane one read.
		if (pins.row_strobe_n && pins.column_strobe_n == 4'hE)
			hid_cycles <= hid_cycles + 1;
		if (rd_valid)
		begin
			rd_last <= rd_data;
			rd_count <= rd_count + 1;
		end
	end
	always @(negedge clk)
		if (rstn)
		begin
			check(32'(ctl_oe & mem_oe), 32'h0000_0000);
			if (pins.row_strobe_n && pins.column_strobe_n == 4'hE)
				check(32'(mem_oe), 32'h0000_0001);
		end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD %0t: saw %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test
	task automatic post(input logic w, input logic [3:0] ln, input logic [19:0] a,
		input logic [3:0] d);
		int n;
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{w, ln, a, d};
		@(negedge clk);
		for (n = 0; req_ready !== 1'b1 && n < 4000; n++)
			@(negedge clk);
		if (n == 4000)
		begin
			fail_count++;
			end_of_test();
		end
		@(posedge clk);
		req_valid <= 1'b0;
	endtask : post
	task automatic wait_reads(input int k);
		for (int n = 0; rd_count < k; n++)
		begin
			@(negedge clk);
			if (n == 600)
			begin
				fail_count++;
				end_of_test();
			end
		end
	endtask : wait_reads
	task automatic t_reset;
		@(negedge clk);
		check(32'(pins), 32'({1'b1, 4'hF, 1'b1, 1'b1, 10'h000}));
		check(32'(ctl_oe), 32'h0000_0000);
	endtask : t_reset
	task automatic t_init;
		post(1'b1, 4'h0, 20'h0_0000, 4'h5);
		post(1'b0, 4'h0, 20'h0_0000, 4'h0);
		wait_reads(rd_count + 1);
		check(32'(rd_last), 32'h0000_0005);
		check(32'(refreshes >= 8), 32'h0000_0001);
		check(32'(refresh_row), 32'(refreshes));
	endtask : t_init
	task automatic t_lanes;
		logic [3:0] e;
		e = 4'hF;
		post(1'b1, 4'h0, 20'h0_05A5, 4'hF);
		for (int i = 0; i < 4; i++)
		begin
			e[i] = 1'b0;
			post(1'b1, 4'(1 << i), 20'h0_05A5, 4'h0);
			post(1'b0, 4'h0, 20'h0_05A5, 4'h0);
			wait_reads(rd_count + 1);
			check(32'(rd_last), 32'(e));
		end
	endtask : t_lanes
	task automatic t_addr;
		post(1'b1, 4'h0, {10'h001, 10'h002}, 4'h3);
		post(1'b1, 4'h0, {10'h002, 10'h001}, 4'hC);
		post(1'b1, 4'h0, {10'h001, 10'h3FF}, 4'h6);
		post(1'b0, 4'h0, {10'h002, 10'h001}, 4'h0);
		wait_reads(rd_count + 1);
		check(32'(rd_last), 32'h0000_000C);
	endtask : t_addr
	task automatic t_page;
		int k;
		k = rd_count;
		f = row_falls;
		post(1'b0, 4'h0, {10'h001, 10'h002}, 4'h0);
		post(1'b0, 4'h0, {10'h001, 10'h3FF}, 4'h0);
		wait_reads(k + 2);
		check(32'(rd_last), 32'h0000_0006);
		check(32'(row_falls - f), 32'h0000_0001);
	endtask : t_page
	task automatic t_hidden;
		int h;
		h = hid_cycles;
		post(1'b1, 4'h0, {10'h002, 10'h010}, 4'h9);
		// Back to back page reads until a refresh interval ends inside one of their column phases.
		for (int n = 0; hid_cycles == h && n < 3000; n++)
			post(1'b0, 4'h1, {10'h002, 10'h010}, 4'h0);
		wait_reads(rd_count + 1);
		check(32'(hid_cycles > h), 32'h0000_0001);
		check(32'(rd_last[0]), 32'h0000_0001);
	endtask : t_hidden
	task automatic t_refresh;
		r = refreshes;
		repeat (2 * 1953 + 200) @(posedge clk);
		check(32'(refreshes - r >= 2), 32'h0000_0001);
		check(32'(refresh_row), 32'(refreshes % 1024));
	endtask : t_refresh
	initial
	begin
		t_reset();
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		t_init();
		t_lanes();
		t_addr();
		t_page();
		t_hidden();
		t_refresh();
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
